/* File: hdl/amp_port_cfg.svh */
// Constants for the amplifier serial control port.
// Assumes inclusion by bare name from the package and design files.
`ifndef AMP_PORT_CFG_SVH
`define AMP_PORT_CFG_SVH
`define WORD_BITS        8
`define CNT_W            4
`define MODE_LSB         0
`define MODE_MSB         2
`define VOL_LSB          3
`define VOL_MSB          7
`define MODE_SPKR_BIT    0
`define MODE_PHONE_BIT   1
`define MODE_LINE_BIT    2
`define WORD_RESET       8'h00
`define LINE_GAIN_MIN_HDB 16'shffbb
`define PHONE_OFFSET_HDB  16'sh000c
`define GAIN_STEP_HDB     16'sh0003
`define SPKR_GAIN_HDB     16'sh0018
`endif

/* File: hdl/amp_port_pkg.sv */
// Types shared by the amplifier serial control port.
// Assumes amp_port_cfg.svh is on the include path.
`include "amp_port_cfg.svh"
package amp_port_pkg;
  // Serial pins after synchronisation
  typedef struct packed {
    logic sclk;
    logic sdata;
    logic serial_enable;
  } serial_pins_t;

  // Decoded output routing
  typedef struct packed {
    logic        output_shutdown_spkr;
    logic        spkr_mute;
    logic        spkr_phone_on;
    logic        output_shutdown_hs;
    logic        hs_phone_on;
    logic        hs_line_on;
    logic [15:0] phone_headset_gain;
    logic [15:0] line_input_gain;
    logic [15:0] spkr_gain;
  } route_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SHIFT = 2'b01,
    ST_FULL = 2'b10
  } port_state_t;
endpackage

/* File: hdl/amp_route_decode.sv */
// Decoder from latched control word to output routing and gains.
// Assumes a stable latched word from the serial port core.
`include "amp_port_cfg.svh"
module amp_route_decode (
  input  wire logic [7:0]            word_i,  // Latched control word
  output amp_port_pkg::route_t       route_o  // Routing and gains
);
  import amp_port_pkg::*;

  logic [2:0]        mode;
  logic [4:0]        vol;
  logic signed [15:0] line_gain;

  assign mode = word_i[`MODE_MSB:`MODE_LSB];
  assign vol  = word_i[`VOL_MSB:`VOL_LSB];
  // Half-dB units avoid fractions; code 0 is the floor
  assign line_gain = 16'(`LINE_GAIN_MIN_HDB + 16'({11'h000, vol}) * `GAIN_STEP_HDB);

  // Mode bits map straight onto path enables
  always_comb begin
    route_o.output_shutdown_spkr = (mode == 3'h0);
    route_o.spkr_phone_on = mode[`MODE_SPKR_BIT];
    route_o.spkr_mute = (mode != 3'h0) && !mode[`MODE_SPKR_BIT];
    route_o.hs_phone_on = mode[`MODE_PHONE_BIT];
    route_o.hs_line_on = mode[`MODE_LINE_BIT];
    route_o.output_shutdown_hs = !mode[`MODE_PHONE_BIT] && !mode[`MODE_LINE_BIT];
    route_o.line_input_gain = line_gain;
    route_o.phone_headset_gain = 16'(line_gain - `PHONE_OFFSET_HDB);
    route_o.spkr_gain = `SPKR_GAIN_HDB;
  end
endmodule

/* File: hdl/amp_serial_port.sv */
// Serial control port: eight-bit word in, routing and gains out.
// Assumes serial pins are asynchronous to clk_i and sclk is well below clk_i/4.
//
// Functional notes
// - Transfer is one eight-bit word shifted
// - Sample data on rising serial clock
// - Enable active high gates transfers
// - Latch only after all eight bits
// - Ignore clocks after eighth until end
// - Extra bits beyond eight are discarded
// - Bits 0..2 select output mode
// - Bits 3..7 form volume code
// - Mode zero shuts down every output
// - Bit0 speaker phone path else mute, except mode zero which shuts down
// - Bit1 phone to headset; shutdown if bits 1 and 2 both clear
// - Bit2 adds line inputs to headset
// - Line gain -34.5 dB, 1.5 dB steps
// - Phone gain six dB below line
// - Speaker gain fixed at 12 dB
`include "amp_port_cfg.svh"
module amp_serial_port (
  input  wire logic                 clk_i,           // System clock 100 MHz
  input  wire logic                 arst_n_i,        // Async reset, active low
  input  wire logic                 sclk_i,          // Serial clock pin
  input  wire logic                 sdata_i,         // Serial data pin
  input  wire logic                 serial_enable_i, // Serial enable pin, active high
  output logic [7:0]                word_o,          // Latched control word
  output amp_port_pkg::route_t      route_o,         // Decoded routing and gains
  output logic                      busy_o           // Transfer in progress
);
  import amp_port_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  serial_pins_t  sync1;
  serial_pins_t  pins;
  logic          sclk_prev;
  logic          en_prev;
  logic          sclk_rise;
  logic          en_fall;

  // Two flops per pin; only the second stage is read
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sync1 <= '0;
      pins  <= '0;
    end else begin
      sync1 <= '{sclk: sclk_i, sdata: sdata_i, serial_enable: serial_enable_i};
      pins  <= sync1;
    end
  end

  // Edge history for serial clock and enable
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_prev <= 1'b0;
      en_prev   <= 1'b0;
    end else begin
      sclk_prev <= pins.sclk;
      en_prev   <= pins.serial_enable;
    end
  end

  assign sclk_rise = pins.sclk && !sclk_prev;
  assign en_fall   = en_prev && !pins.serial_enable;

  ////////////////////////////////////////////////////////////////////////
  // Transfer state
  port_state_t       state;
  port_state_t       next_state;
  logic [`CNT_W-1:0] bit_cnt;
  logic [7:0]        shift;

  // Data sits stable around the rising edge, so sampling the synced
  // copy together with the synced clock keeps them aligned
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: begin
        if (pins.serial_enable) begin
          next_state = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        if (!pins.serial_enable) begin
          next_state = ST_IDLE;
        end else if (sclk_rise && bit_cnt == 4'(`WORD_BITS - 1)) begin
          next_state = ST_FULL;
        end
      end
      ST_FULL: begin
        if (!pins.serial_enable) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bit counter; held at zero while enable is low
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      bit_cnt <= '0;
    end else if (!pins.serial_enable) begin
      bit_cnt <= '0;
    end else if (state == ST_SHIFT && sclk_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
    end
  end

  // LSB first: each bit enters at the top and walks down
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift <= `WORD_RESET;
    end else if (state == ST_SHIFT && pins.serial_enable && sclk_rise) begin
      shift <= {pins.sdata, shift[7:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Word latch
  // Only a full word survives the enable fall; partial words are
  // dropped so a glitchy host cannot half-change the gains
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      word_o <= `WORD_RESET;
    end else if (en_fall && state == ST_FULL) begin
      word_o <= shift;
    end
  end

  assign busy_o = (state != ST_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Routing decode
  amp_route_decode u_decode (
    .word_i  (word_o),
    .route_o (route_o)
  );
endmodule

/* File: tb/amp_host_model.sv */
// Host model that drives the serial control port pins.
// Assumes the bench calls send only after reset is released.
module amp_host_model (
  input  wire logic clk_i,           // System clock
  output logic      sclk_o,          // Serial clock, still between frames
  output logic      sdata_o,         // Serial data
  output logic      serial_enable_o  // Frame enable, active high
);
  timeunit 1ns;
  timeprecision 1ps;
  // Idle pins: clock low, frame closed
  initial begin
    sclk_o = 1'b0;
    sdata_o = 1'b0;
    serial_enable_o = 1'b0;
  end
  ////////////////////////////////////////
  // Sends n bits of w with a 160 ns serial clock
  task automatic send(input logic [15:0] w, input int n);
    @(negedge clk_i) serial_enable_o = 1'b1;
    for (int i = 0; i < n; i++) begin
      sdata_o = w[i];
      repeat (8) @(negedge clk_i);
      sclk_o = 1'b1;
      repeat (8) @(negedge clk_i);
      sclk_o = 1'b0;
    end
    repeat (4) @(negedge clk_i);
    serial_enable_o = 1'b0;
    sdata_o = ~sdata_o; // Released line must not hold the last bit
  endtask
endmodule

/* File: tb/amp_serial_port_sva.sv */
// Checker for the serial control port, sees only its ports.
// Assumes the package is compiled first; bound below.
module amp_serial_port_sva
  import amp_port_pkg::*;
(
  input wire logic                 clk_i,           // System clock
  input wire logic                 arst_n_i,        // Async reset
  input wire logic                 sclk_i,          // Serial clock
  input wire logic                 sdata_i,         // Serial data
  input wire logic                 serial_enable_i, // Frame enable
  input wire logic [7:0]           word_o,          // Latched word
  input wire amp_port_pkg::route_t route_o,         // Routing
  input wire logic                 busy_o           // Busy
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);
  ////////////////////////////////////////
  // Latch only after the frame closes, since the pins pass a synchroniser
  property p_latch; $changed(word_o) |-> !$past(serial_enable_i, 2); endproperty
  property p_idle; !serial_enable_i [*8] |-> !busy_o; endproperty
  property p_sd0; route_o.output_shutdown_spkr == (word_o[2:0] == 3'h0); endproperty
  property p_spk;
    route_o.spkr_phone_on == word_o[0] && route_o.spkr_mute == (!word_o[0] && word_o[2:1] != 2'h0);
  endproperty
  property p_hs;
    route_o.hs_phone_on == word_o[1] && route_o.hs_line_on == word_o[2]
      && route_o.output_shutdown_hs == (word_o[2:1] == 2'h0);
  endproperty
  property p_line; $signed(route_o.line_input_gain) == -69 + 3 * $signed({1'b0, word_o[7:3]}); endproperty
  property p_phone; $signed(route_o.phone_headset_gain) == $signed(route_o.line_input_gain) - 12; endproperty
  property p_spkr; route_o.spkr_gain == 16'h0018; endproperty
  a_latch: assert property (p_latch) else $error("word changed inside frame");
  a_idle: assert property (p_idle) else $error("busy with enable low");
  a_sd0: assert property (p_sd0) else $error("speaker shutdown wrong");
  a_spk: assert property (p_spk) else $error("speaker path wrong");
  a_hs: assert property (p_hs) else $error("headset path wrong");
  a_line: assert property (p_line) else $error("line gain wrong");
  a_phone: assert property (p_phone) else $error("phone gain wrong");
  a_spkr: assert property (p_spkr) else $error("speaker gain wrong");
  c_word: cover property ($changed(word_o));
  c_mode7: cover property (word_o[2:0] == 3'h7);
  c_busy: cover property ($rose(busy_o));
endmodule
bind amp_serial_port amp_serial_port_sva u_sva (.clk_i, .arst_n_i, .sclk_i, .sdata_i, .serial_enable_i,
  .word_o, .route_o, .busy_o);

/* File: tb/tb.sv */
// Self-checking bench for the serial control port.
// Assumes host model and checker are compiled before it.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                 clk_i, arst_n_i, sclk_i, sdata_i, serial_enable_i, busy_o;
  logic [7:0]           word_o;
  amp_port_pkg::route_t route_o;
  int                   err_total = 0;
  int                   comparisons = 0;
  amp_serial_port u_dut (.clk_i, .arst_n_i, .sclk_i, .sdata_i, .serial_enable_i, .word_o, .route_o, .busy_o);
  amp_host_model u_host (.clk_i, .sclk_o(sclk_i), .sdata_o(sdata_i), .serial_enable_o(serial_enable_i));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Frame plus settling time past the synchroniser
  task automatic frame(input logic [15:0] w, input int n);
    u_host.send(w, n);
    repeat (10) @(negedge clk_i);
  endtask
  // Every mode, volume rising to the top code
  task automatic t_modes();
    logic [7:0] w;
    for (int m = 0; m < 8; m++) begin
      w = {5'(m * 4 + 3), 3'(m)};
      frame({8'h00, w}, 8);
      chk(word_o, w);
      chk(route_o.line_input_gain, 16'(-69 + 3 * w[7:3]));
      chk(route_o.phone_headset_gain, 16'(-81 + 3 * w[7:3]));
      chk(route_o.output_shutdown_hs, w[2:1] == 2'h0);
      chk(route_o.hs_line_on, w[2]);
      chk(route_o.spkr_mute, !w[0] && w[2:1] != 2'h0);
      chk(route_o.spkr_phone_on, w[0]);
      chk(route_o.hs_phone_on, w[1]);
      chk(route_o.output_shutdown_spkr, w[2:0] == 3'h0);
      chk(busy_o, 1'b0);
    end
  endtask
  // Twelve bits: only the first eight count
  task automatic t_long();
    frame(16'h0f05, 12);
    chk(word_o, 8'h05);
  endtask
  // Short frame dropped, next full frame lands cleanly
  task automatic t_short();
    frame(16'h00ff, 5);
    chk(word_o, 8'h05);
    frame(16'h0002, 8);
    chk(word_o, 8'h02);
    chk(route_o.line_input_gain, 16'hffbb);
    chk(route_o.spkr_gain, 16'h0018);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    arst_n_i = 1'b0;
    repeat (10) @(negedge clk_i);
    arst_n_i = 1'b1;
    chk(word_o, 8'h00);
    chk(busy_o, 1'b0);
    repeat (2) @(negedge clk_i);
    t_modes();
    t_long();
    t_short();
    complete_run();
  end
  // Watchdog well beyond eleven frames
  initial begin
    #300000;
    err_total++;
    complete_run();
  end
endmodule
